// *** pkg/lcefs_pkg.sv ***
// Purpose: Shared constants for the lane code error status flags block
// Assumes: 8-bit register data, 12-bit register address, 8 lanes per link
// Notes: Offsets are byte addresses on the plain register port
package lcefs_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int LANES = 8;
   localparam int CNT_W = 8;
   localparam int PAGE_W = 1;
   // Register offsets
   localparam logic [ADDR_W-1:0] ADDR_LINK_PAGE = 12'h300;
   localparam logic [ADDR_W-1:0] ADDR_BAD_CODE = 12'h46E;
   localparam logic [ADDR_W-1:0] ADDR_STRAY_CTRL = 12'h46F;
   localparam logic [ADDR_W-1:0] ADDR_THRESH = 12'h480;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 12'h481;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h482;
   localparam logic [ADDR_W-1:0] ADDR_CNT_CLR = 12'h483;
   // Reset values
   localparam logic [DATA_W-1:0] FLAGS_RST = 8'h00;
   localparam logic [CNT_W-1:0] THRESH_RST = 8'hFF;
   localparam logic [DATA_W-1:0] IRQ_MASK_RST = 8'h00;
   localparam logic [PAGE_W-1:0] PAGE_RST = 1'h0;
   // Interrupt status bit positions
   localparam int IRQ_BAD_BIT = 0;
   localparam int IRQ_STRAY_BIT = 1;
   localparam int IRQ_BITS = 2;
   // Counter clear register bit
   localparam int CLR_BIT = 0;
endpackage

// *** logic/lcefs_err_cnt.sv ***
// Purpose: One saturating per-lane error counter with threshold compare
// Assumes: err_evt is a one-cycle pulse from logic on the same clock
// Notes: Clear wins over a coincident event
`timescale 1ns/1ns
module lcefs_err_cnt #(
   parameter int CNT_W = lcefs_pkg::CNT_W
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic err_evt,
   input wire logic clr,
   input wire logic [CNT_W-1:0] thresh,
   output logic [CNT_W-1:0] count,
   output logic flag
);
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;

   // Next count: clear, else saturating increment
   always_comb
   begin
      count_nxt = count_r;
      if (clr)
      begin
         count_nxt = '0;
      end
      else if (err_evt && (count_r != {CNT_W{1'b1}}))
      begin
         count_nxt = count_r + 1'b1;
      end
   end

   // Count register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_r <= '0;
      end
      else
      begin
         count_r <= count_nxt;
      end
   end

   // Flag high once the count reaches the threshold
   assign flag = (count_r >= thresh);
   assign count = count_r;

   property p_cnt_step;
      @(posedge clk) disable iff (!rst_n)
      (err_evt && !clr && count_r != {CNT_W{1'b1}}) |=> (count_r == $past(count_r) + 1'b1);
   endproperty
   a_cnt_step: assert property (p_cnt_step) else $error("error counter did not step");

   property p_flag_cross;
      @(posedge clk) disable iff (!rst_n)
      (err_evt && !clr && thresh != '0 && count_r == thresh - 1'b1 && $stable(thresh)) ##1 $stable(thresh)
         |-> flag && !$past(flag);
   endproperty
   a_flag_cross: assert property (p_flag_cross) else $error("flag did not rise at threshold");

   property p_clr_low;
      @(posedge clk) disable iff (!rst_n)
      clr ##1 (thresh != '0) |-> (count_r == '0) && !flag;
   endproperty
   a_clr_low: assert property (p_clr_low) else $error("flag not low after clear");
endmodule

// *** logic/lcefs_flags.sv ***
// Purpose: Per-lane code error counters, threshold flags, paged status registers
// Assumes: Error pulses come from lane decoders on clk; one lane per bit
// Notes: Flags are read through the link page register; rising flags raise irq when their status bit is unmasked
// Notes on behaviour
// - Read-only bad code flag per lane, lane n in bit n, resets to zero
// - Read-only stray control character flag register at 0x46F, lane n in bit n
// - Flag is one when lane count is at or above the 8-bit threshold
// - Flag reads show the link chosen by the page control at 0x300
`timescale 1ns/1ns
module lcefs_flags #(
   parameter int NUM_LINKS = 2
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [NUM_LINKS*lcefs_pkg::LANES-1:0] bad_code_evt,
   input wire logic [NUM_LINKS*lcefs_pkg::LANES-1:0] stray_ctrl_evt,
   input wire logic [lcefs_pkg::ADDR_W-1:0] addr,
   input wire logic [lcefs_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [lcefs_pkg::DATA_W-1:0] rd_data,
   output logic irq
);
   localparam int LN = lcefs_pkg::LANES;
   localparam int DW = lcefs_pkg::DATA_W;

   logic [lcefs_pkg::PAGE_W-1:0] page_r;
   logic [lcefs_pkg::PAGE_W-1:0] page_nxt;
   logic [lcefs_pkg::CNT_W-1:0] thresh_r;
   logic [lcefs_pkg::CNT_W-1:0] thresh_nxt;
   logic [DW-1:0] mask_r;
   logic [DW-1:0] mask_nxt;
   logic [lcefs_pkg::IRQ_BITS-1:0] stat_r;
   logic [lcefs_pkg::IRQ_BITS-1:0] stat_nxt;
   logic [DW-1:0] rd_data_r;
   logic [DW-1:0] rd_data_nxt;
   logic [NUM_LINKS*LN-1:0] bad_flags;
   logic [NUM_LINKS*LN-1:0] stray_flags;
   logic [NUM_LINKS*LN-1:0] bad_prev_r;
   logic [NUM_LINKS*LN-1:0] stray_prev_r;
   logic [NUM_LINKS-1:0] clr_link;
   logic [LN-1:0] bad_sel;
   logic [LN-1:0] stray_sel;
   logic [LN-1:0] link0_bad;
   logic bad_rise;
   logic stray_rise;

   // Pick one link's lane flags; an out-of-range page reads zero
   function automatic logic [LN-1:0] link_flags(input logic [NUM_LINKS*LN-1:0] all,
                                                 input logic [lcefs_pkg::PAGE_W-1:0] pg);
      logic [LN-1:0] res;
      res = lcefs_pkg::FLAGS_RST;
      for (int l = 0; l < NUM_LINKS; l++)
      begin
         if (int'(pg) == l)
         begin
            res = all[l*LN +: LN];
         end
      end
      return res;
   endfunction

   // Counter clear strobe for the currently paged link
   always_comb
   begin
      clr_link = '0;
      for (int l = 0; l < NUM_LINKS; l++)
      begin
         if (wr_en && addr == lcefs_pkg::ADDR_CNT_CLR && wr_data[lcefs_pkg::CLR_BIT] && int'(page_r) == l)
         begin
            clr_link[l] = 1'b1;
         end
      end
   end

   // One counter per link, lane and error type
   for (genvar g = 0; g < NUM_LINKS*LN; g++)
   begin : g_lane
      lcefs_err_cnt #(.CNT_W(lcefs_pkg::CNT_W)) u_bad (
         .clk(clk),
         .rst_n(rst_n),
         .err_evt(bad_code_evt[g]),
         .clr(clr_link[g/LN]),
         .thresh(thresh_r),
         .count(),
         .flag(bad_flags[g])
      );
      lcefs_err_cnt #(.CNT_W(lcefs_pkg::CNT_W)) u_stray (
         .clk(clk),
         .rst_n(rst_n),
         .err_evt(stray_ctrl_evt[g]),
         .clr(clr_link[g/LN]),
         .thresh(thresh_r),
         .count(),
         .flag(stray_flags[g])
      );
   end

   // Paged view of the flags
   assign bad_sel = link_flags(bad_flags, page_r);
   assign stray_sel = link_flags(stray_flags, page_r);

   // Link zero bad code flags, watched by the paging check
   assign link0_bad = bad_flags[LN-1:0];

   // Any flag of any link going high is an interrupt event
   assign bad_rise = |(bad_flags & ~bad_prev_r);
   assign stray_rise = |(stray_flags & ~stray_prev_r);

   // Control registers, sticky status and read data
   always_comb
   begin
      page_nxt = page_r;
      thresh_nxt = thresh_r;
      mask_nxt = mask_r;
      stat_nxt = stat_r;
      rd_data_nxt = '0;
      if (wr_en)
      begin
         case (addr)
            lcefs_pkg::ADDR_LINK_PAGE: page_nxt = wr_data[lcefs_pkg::PAGE_W-1:0];
            lcefs_pkg::ADDR_THRESH: thresh_nxt = wr_data[lcefs_pkg::CNT_W-1:0];
            lcefs_pkg::ADDR_IRQ_MASK: mask_nxt = wr_data;
            lcefs_pkg::ADDR_IRQ_STAT: stat_nxt = stat_r & ~wr_data[lcefs_pkg::IRQ_BITS-1:0];
            default: ;
         endcase
      end
      // Set wins over a coincident write-one clear
      if (bad_rise)
      begin
         stat_nxt[lcefs_pkg::IRQ_BAD_BIT] = 1'b1;
      end
      if (stray_rise)
      begin
         stat_nxt[lcefs_pkg::IRQ_STRAY_BIT] = 1'b1;
      end
      if (rd_en)
      begin
         case (addr)
            lcefs_pkg::ADDR_LINK_PAGE: rd_data_nxt[lcefs_pkg::PAGE_W-1:0] = page_r;
            lcefs_pkg::ADDR_BAD_CODE: rd_data_nxt = bad_sel;
            lcefs_pkg::ADDR_STRAY_CTRL: rd_data_nxt = stray_sel;
            lcefs_pkg::ADDR_THRESH: rd_data_nxt = thresh_r;
            lcefs_pkg::ADDR_IRQ_STAT: rd_data_nxt[lcefs_pkg::IRQ_BITS-1:0] = stat_r;
            lcefs_pkg::ADDR_IRQ_MASK: rd_data_nxt = mask_r;
            default: rd_data_nxt = '0;
         endcase
      end
   end

   // Register update
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         page_r <= lcefs_pkg::PAGE_RST;
         thresh_r <= lcefs_pkg::THRESH_RST;
         mask_r <= lcefs_pkg::IRQ_MASK_RST;
         stat_r <= '0;
         rd_data_r <= '0;
         bad_prev_r <= '0;
         stray_prev_r <= '0;
      end
      else
      begin
         page_r <= page_nxt;
         thresh_r <= thresh_nxt;
         mask_r <= mask_nxt;
         stat_r <= stat_nxt;
         rd_data_r <= rd_data_nxt;
         bad_prev_r <= bad_flags;
         stray_prev_r <= stray_flags;
      end
   end

   assign rd_data = rd_data_r;
   // Level interrupt while any unmasked status bit is set
   assign irq = |(stat_r & mask_r[lcefs_pkg::IRQ_BITS-1:0]);

   property p_bad_read;
      @(posedge clk) disable iff (!rst_n)
      (rd_en && addr == lcefs_pkg::ADDR_BAD_CODE) |=> (rd_data == $past(bad_sel));
   endproperty
   a_bad_read: assert property (p_bad_read) else $error("bad code flag read mismatch");

   property p_stray_read;
      @(posedge clk) disable iff (!rst_n)
      (rd_en && addr == lcefs_pkg::ADDR_STRAY_CTRL) |=> (rd_data == $past(stray_sel));
   endproperty
   a_stray_read: assert property (p_stray_read) else $error("stray control flag read mismatch");

   property p_page_follow;
      @(posedge clk) disable iff (!rst_n)
      (wr_en && addr == lcefs_pkg::ADDR_LINK_PAGE && wr_data[lcefs_pkg::PAGE_W-1:0] == '0)
         ##1 (rd_en && addr == lcefs_pkg::ADDR_BAD_CODE) |=> (rd_data == $past(link0_bad));
   endproperty
   a_page_follow: assert property (p_page_follow) else $error("paged read not from link zero");

   property p_thresh_write;
      @(posedge clk) disable iff (!rst_n)
      (wr_en && addr == lcefs_pkg::ADDR_THRESH) |=> (thresh_r == $past(wr_data));
   endproperty
   a_thresh_write: assert property (p_thresh_write) else $error("threshold not taken");

   property p_rise_irq;
      @(posedge clk) disable iff (!rst_n)
      (bad_rise && mask_r[lcefs_pkg::IRQ_BAD_BIT] && !(wr_en && addr == lcefs_pkg::ADDR_IRQ_MASK)) |=> irq;
   endproperty
   a_rise_irq: assert property (p_rise_irq) else $error("flag rise did not raise irq");

   property p_rd_idle;
      @(posedge clk) disable iff (!rst_n)
      !rd_en |=> (rd_data == '0);
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero after an idle cycle");

   property p_bad_set;
      @(posedge clk) disable iff (!rst_n)
      bad_rise |=> stat_r[lcefs_pkg::IRQ_BAD_BIT];
   endproperty
   a_bad_set: assert property (p_bad_set) else $error("bad code flag rise not latched in status");

   property p_stray_set;
      @(posedge clk) disable iff (!rst_n)
      stray_rise |=> stat_r[lcefs_pkg::IRQ_STRAY_BIT];
   endproperty
   a_stray_set: assert property (p_stray_set) else $error("stray control flag rise not latched in status");
endmodule

// *** tb/lcefs_lane_tx.sv ***
// Purpose: Far-side transmitter model that emits lane error pulses
// Assumes: One pulse per cycle on one chosen lane bit, on the bench clock
// Notes: Burst length is taken at the start strobe; outputs stay low between bursts
`timescale 1ns/1ns
module lcefs_lane_tx #(
   parameter int BITS = 16
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic kind,
   input wire logic [4:0] bit_idx,
   input wire logic [3:0] num,
   output logic [BITS-1:0] bad_code_evt,
   output logic [BITS-1:0] stray_ctrl_evt,
   output logic busy
);
   logic [3:0] rem_r;
   logic [3:0] rem_nxt;
   logic kind_r;
   logic [4:0] idx_r;
   // Remaining pulses of the burst
   always_comb
   begin
      rem_nxt = busy ? rem_r - 4'h1 : rem_r;
      if (start)
      begin
         rem_nxt = num;
      end
   end
   // Register burst state; lane target captured at start
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rem_r <= 4'h0;
         kind_r <= 1'b0;
         idx_r <= 5'h00;
      end
      else
      begin
         rem_r <= rem_nxt;
         kind_r <= start ? kind : kind_r;
         idx_r <= start ? bit_idx : idx_r;
      end
   end
   assign busy = rem_r != 4'h0;
   // One pulse per cycle on the chosen lane only
   always_comb
   begin
      bad_code_evt = '0;
      stray_ctrl_evt = '0;
      if (busy && kind_r)
         stray_ctrl_evt[idx_r] = 1'b1;
      else if (busy)
         bad_code_evt[idx_r] = 1'b1;
   end
endmodule

// *** tb/lcefs_flags_bench.sv ***
// Purpose: Self-checking bench for the lane code error status flags
// Assumes: Register port with read data one cycle after the strobe
// Notes: Per-lane counts are mirrored here and saturate at 255
`timescale 1ns/1ns
module lcefs_flags_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [7:0] wr_data = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic start = 1'b0;
   logic kind = 1'b0;
   logic [4:0] bit_idx = 5'h00;
   logic [3:0] num = 4'h0;
   logic [15:0] bad_code_evt;
   logic [15:0] stray_ctrl_evt;
   logic [7:0] rd_data;
   logic irq;
   logic busy;
   logic [7:0] th;
   logic [7:0] d;
   int err_count = 0;
   int checks = 0;
   int seed_v;
   int cnt [2][2][8];
   lcefs_flags #(.NUM_LINKS(2)) lcefs_flags_inst (.clk(clk), .rst_n(rst_n), .bad_code_evt(bad_code_evt),
      .stray_ctrl_evt(stray_ctrl_evt), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
      .rd_data(rd_data), .irq(irq));
   lcefs_lane_tx #(.BITS(16)) lcefs_lane_tx_inst (.clk(clk), .rst_n(rst_n), .start(start), .kind(kind),
      .bit_idx(bit_idx), .num(num), .bad_code_evt(bad_code_evt), .stray_ctrl_evt(stray_ctrl_evt), .busy(busy));
   // 25 MHz clock
   always #20 clk = ~clk;
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= v;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [11:0] a, output logic [7:0] v);
      @(posedge clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      v = rd_data;
   endtask
   // Page write and read with no idle cycle between the strobes
   task automatic page_rd(input logic [7:0] p, input logic [11:0] a, output logic [7:0] v);
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= 12'h0300;
      wr_data <= p;
      @(posedge clk);
      wr_en <= 1'b0;
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      v = rd_data;
   endtask
   function automatic logic [7:0] exp_flags(input int k, input int l);
      logic [7:0] f;
      for (int n = 0; n < 8; n++)
         f[n] = cnt[k][l][n] >= th;
      return f;
   endfunction
   // Burst of p error pulses on lane n of link l, mirrored in the expected counts
   task automatic send(input int k, input int l, input int n, input int p);
      @(posedge clk);
      start <= 1'b1;
      kind <= k[0];
      bit_idx <= 5'(l * 8 + n);
      num <= 4'(p);
      @(posedge clk);
      start <= 1'b0;
      #1;
      for (int i = 0; i < 20 && busy; i++)
         @(posedge clk);
      repeat (2) @(posedge clk);
      #1;
      cnt[k][l][n] = (cnt[k][l][n] + p > 255) ? 255 : cnt[k][l][n] + p;
   endtask
   task automatic check_all();
      for (int l = 0; l < 2; l++)
      begin
         page_rd(8'(l), 12'h046E, d);
         chk("bad code flags", d, exp_flags(0, l));
         rd(12'h046F, d);
         chk("stray control flags", d, exp_flags(1, l));
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Watchdog against a hung run
   initial
   begin
      #(40 * 60000);
      err_count++;
      tally_and_finish();
   end
   initial
   begin
      seed_v = $urandom(1);
      cnt = '{default: 0};
      th = 8'hFF;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd(12'h046E, d);
      chk("bad code reset", d, 8'h00);
      rd(12'h046F, d);
      chk("stray control reset", d, 8'h00);
      rd(12'h0480, d);
      chk("threshold reset", d, 8'hFF);
      rd(12'h0123, d);
      chk("unmapped read", d, 8'h00);
      wr(12'h046F, 8'hFF);
      rd(12'h046F, d);
      chk("read-only write", d, 8'h00);
      $display("test reset done");
      th = 8'h01;
      wr(12'h0480, th);
      send(0, 0, 0, 1);
      chk("irq masked", {7'h00, irq}, 8'h00);
      rd(12'h0481, d);
      chk("irq status", d, 8'h01);
      wr(12'h0482, 8'h03);
      chk("irq unmasked", {7'h00, irq}, 8'h01);
      wr(12'h0481, 8'h01);
      chk("irq cleared", {7'h00, irq}, 8'h00);
      send(1, 0, 3, 1);
      chk("stray irq", {7'h00, irq}, 8'h01);
      rd(12'h0481, d);
      chk("stray irq status", d, 8'h02);
      wr(12'h0481, 8'h02);
      chk("stray irq cleared", {7'h00, irq}, 8'h00);
      check_all();
      $display("test interrupt done");
      repeat (6)
      begin
         th = 8'($urandom_range(1, 4));
         wr(12'h0480, th);
         repeat (5) send($urandom_range(0, 1), $urandom_range(0, 1), $urandom_range(0, 7), $urandom_range(0, 4));
         check_all();
      end
      $display("test random done");
      th = 8'h00;
      wr(12'h0480, th);
      check_all();
      th = 8'hFF;
      wr(12'h0480, th);
      repeat (18) send(1, 1, 7, 15);
      check_all();
      $display("test threshold bounds done");
      wr(12'h0300, 8'h01);
      wr(12'h0483, 8'h01);
      cnt[0][1] = '{default: 0};
      cnt[1][1] = '{default: 0};
      th = 8'h01;
      wr(12'h0480, th);
      check_all();
      $display("test counter clear done");
      tally_and_finish();
   end
endmodule
